// ==== asp_pkg.sv ====
// Shared constants for the asynchronous serial data port.
package asp_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [2:0] ASP_IDX_CTRL   = 3'h0;
    localparam logic [2:0] ASP_IDX_ERR_EN = 3'h1;
    localparam logic [2:0] ASP_IDX_STAT   = 3'h2;
    localparam logic [2:0] ASP_IDX_BAUD   = 3'h3;
    localparam logic [2:0] ASP_IDX_NINTH  = 3'h4;
    localparam logic [2:0] ASP_IDX_IRQ_ST = 3'h5;
    localparam logic [2:0] ASP_IDX_DATA   = 3'h7;
    localparam int         ASP_ADR_W      = 5;

    // ==========================================================
    // Control register fields
    localparam int ASP_CTRL_NINE   = 0;
    localparam int ASP_CTRL_TWOSTP = 1;
    localparam int ASP_CTRL_PAR_EN = 2;
    localparam int ASP_CTRL_PAR_OD = 3;
    localparam int ASP_CTRL_TX_EN  = 4;
    localparam int ASP_CTRL_RX_EN  = 5;
    localparam int ASP_CTRL_W      = 6;
    localparam logic [5:0] ASP_CTRL_RST = 6'h30;

    // ==========================================================
    // Event bits of status, enable and sticky
    localparam int ASP_EV_PARITY  = 0;
    localparam int ASP_EV_FRAMING = 1;
    localparam int ASP_EV_NOISE   = 2;
    localparam int ASP_EV_OVERRUN = 3;
    localparam int ASP_EV_RX_FULL = 4;
    localparam int ASP_EV_TX_EMPT = 5;
    localparam int ASP_EV_TX_DONE = 6;
    localparam int ASP_EV_W       = 7;
    localparam logic [6:0] ASP_EV_RST   = 7'h60;
    localparam logic [6:0] ASP_EN_RST   = 7'h00;
    localparam logic [7:0] ASP_DATA_RST = 8'h00;

    // Ninth bit register fields
    localparam int ASP_NINTH_TX = 6;
    localparam int ASP_NINTH_RX = 7;

    // ==========================================================
    // Timing: 16 samples per bit, vote of 7 to 9
    localparam int          ASP_DIV_W    = 16;
    localparam int          ASP_CLK_HZ   = 125000000;
    localparam int          ASP_BAUD_DEF = 115200;
    localparam int          ASP_OVERSMP  = 16;
    localparam logic [15:0] ASP_BAUD_RST = 16'((ASP_CLK_HZ + ASP_OVERSMP * ASP_BAUD_DEF / 2)
                                               / (ASP_OVERSMP * ASP_BAUD_DEF));
    localparam logic [3:0]  ASP_SMP_A    = 4'h7;
    localparam logic [3:0]  ASP_SMP_C    = 4'h9;
    localparam logic [3:0]  ASP_BIT_END  = 4'hF;

    // Phase of a serial frame, one-hot
    typedef enum logic [3:0] {
        ASP_PH_IDLE  = 4'b0001,
        ASP_PH_START = 4'b0010,
        ASP_PH_DATA  = 4'b0100,
        ASP_PH_STOP  = 4'b1000
    } asp_ph_t;

endpackage : asp_pkg

// ==== asp_baud_gen.sv ====
// Common baud generator: one sample tick at sixteen times the bit rate.
`timescale 1ns/1ns
module asp_baud_gen #(
    parameter int DIV_W = asp_pkg::ASP_DIV_W
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [DIV_W-1:0] divisor_i,
    output logic                  tick_o
);
    import asp_pkg::*;

    logic [DIV_W-1:0] cnt_ff;

    // ==========================================================
    // Elaboration check
    if (DIV_W < 2) begin : g_chk
        $error("asp_baud_gen: DIV_W must be at least 2");
    end

    // ==========================================================
    // Divider; a divisor of zero or one still ticks every cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
            tick_o <= 1'b0;
        end else if (cnt_ff + DIV_W'(1) >= divisor_i) begin
            cnt_ff <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + DIV_W'(1);
            tick_o <= 1'b0;
        end
    end

endmodule : asp_baud_gen

// ==== asp_serial_port.sv ====
// Asynchronous serial port with shared data register and error interrupts.
//
// Contract
// - Overrun interrupt enable set: overrun flag requests an interrupt.
// - Noise interrupt enable, bit 2, gates the noise flag onto interrupt.
// - Framing interrupt enable, bit 1, gates the framing error flag.
// - Parity interrupt enable, bit 0, gates the parity error flag.
// - Data address: reads give receive buffer, writes load transmit buffer.
// - Data reads and writes complete the automatic flag clearing steps.
// - Data register is eight bits, bit n to bit n, reset zero.
// - Link is full duplex, asynchronous, NRZ, no shared clock.
// - Transmitter and receiver run independently from one baud generator.
// - Character arriving while receive buffer full sets overrun, is discarded.
// - Free shifter takes waiting transmit value on baud tick, sets empty flag.
// - Frame: low start, 8 or 9 data bits LSB first, 1 or 2 stops.
`timescale 1ns/1ns
module asp_serial_port #(
    parameter int DIV_W = asp_pkg::ASP_DIV_W
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [asp_pkg::ASP_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [31:0]                    wb_dat_i,
    output logic      [31:0]                    wb_dat_o,
    output logic                                wb_ack_o,
    input  wire logic                           rxd_i,
    output logic                                txd_o,
    output logic                                irq_o
);
    import asp_pkg::*;

    if (DIV_W < 4 || DIV_W > 16) begin : g_chk
        $error("asp_serial_port: DIV_W must lie in 4..16");
    end

    logic [ASP_CTRL_W-1:0] ctrl_ff;
    logic [ASP_EV_W-1:0]   err_en_ff;
    logic [ASP_EV_W-1:0]   flags_ff;
    logic [ASP_EV_W-1:0]   sticky_ff;
    logic [ASP_EV_W-1:0]   armed_ff;
    logic [DIV_W-1:0]      baud_ff;
    logic [7:0]            rx_buf_ff;
    logic                  rx_ninth_ff;
    logic [7:0]            tx_buf_ff;
    logic                  tx_ninth_ff;
    logic                  tick;

    // ==========================================================
    // Bus decode; one-cycle answer
    logic       req;
    logic       wr_go;
    logic       rd_go;
    logic [2:0] idx;
    logic       data_rd;
    logic       data_wr;
    logic       stat_rd;

    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_go   = req & wb_we_i & wb_sel_i[0];
    assign rd_go   = req & ~wb_we_i;
    assign idx     = wb_adr_i[4:2];
    assign data_rd = rd_go & (idx == ASP_IDX_DATA);
    assign data_wr = wr_go & (idx == ASP_IDX_DATA);
    assign stat_rd = rd_go & (idx == ASP_IDX_STAT);

    // Ack pulse, one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Read mux; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_go) begin
            case (idx)
                ASP_IDX_CTRL:   wb_dat_o <= 32'(ctrl_ff);
                ASP_IDX_ERR_EN: wb_dat_o <= 32'(err_en_ff);
                ASP_IDX_STAT:   wb_dat_o <= 32'(flags_ff);
                ASP_IDX_BAUD:   wb_dat_o <= 32'(baud_ff);
                ASP_IDX_NINTH:  wb_dat_o <= 32'({rx_ninth_ff, tx_ninth_ff, 6'h00});
                ASP_IDX_IRQ_ST: wb_dat_o <= 32'(sticky_ff);
                ASP_IDX_DATA:   wb_dat_o <= 32'(rx_buf_ff);
                default:        wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Writable configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff     <= ASP_CTRL_RST;
            err_en_ff   <= ASP_EN_RST;
            baud_ff     <= DIV_W'(ASP_BAUD_RST);
            tx_ninth_ff <= 1'b0;
        end else if (wr_go) begin
            case (idx)
                ASP_IDX_CTRL:   ctrl_ff     <= wb_dat_i[ASP_CTRL_W-1:0];
                ASP_IDX_ERR_EN: err_en_ff   <= wb_dat_i[ASP_EV_W-1:0];
                ASP_IDX_BAUD:   baud_ff     <= wb_dat_i[DIV_W-1:0];
                ASP_IDX_NINTH:  tx_ninth_ff <= wb_dat_i[ASP_NINTH_TX];
                default:        ;
            endcase
        end
    end

    // Write-only transmit buffer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_buf_ff <= ASP_DATA_RST;
        end else if (data_wr) begin
            tx_buf_ff <= wb_dat_i[7:0];
        end
    end

    // ==========================================================
    // Shared baud generator
    asp_baud_gen #(
        .DIV_W     (DIV_W)
    ) u_baud (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .divisor_i (baud_ff),
        .tick_o    (tick)
    );

    // ==========================================================
    // Transmitter
    asp_ph_t     tx_ph_ff;
    logic [3:0]  tx_smp_ff;
    logic [3:0]  tx_bit_ff;
    logic [8:0]  tx_sh_ff;
    logic        tx_load;
    logic        tx_bit_end;
    logic [3:0]  nbits;
    logic [8:0]  tx_word;

    assign nbits      = ctrl_ff[ASP_CTRL_NINE] ? 4'h9 : 4'h8;
    assign tx_bit_end = tick & (tx_smp_ff == ASP_BIT_END);
    // Free shifter takes waiting char on a tick
    assign tx_load    = tick & (tx_ph_ff == ASP_PH_IDLE) & ~flags_ff[ASP_EV_TX_EMPT]
                        & ctrl_ff[ASP_CTRL_TX_EN];

    // Parity replaces the last data bit
    always_comb begin
        tx_word = {tx_ninth_ff, tx_buf_ff};
        if (ctrl_ff[ASP_CTRL_PAR_EN]) begin
            if (ctrl_ff[ASP_CTRL_NINE]) begin
                tx_word[8] = ^tx_buf_ff ^ ctrl_ff[ASP_CTRL_PAR_OD];
            end else begin
                tx_word[7] = ^tx_buf_ff[6:0] ^ ctrl_ff[ASP_CTRL_PAR_OD];
            end
        end
    end

    // Transmit sequencer; line idles high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_ph_ff  <= ASP_PH_IDLE;
            tx_smp_ff <= 4'h0;
            tx_bit_ff <= 4'h0;
            tx_sh_ff  <= 9'h000;
            txd_o     <= 1'b1;
        end else begin
            if (tick) begin
                tx_smp_ff <= tx_smp_ff + 4'h1;
            end
            case (tx_ph_ff)
                ASP_PH_IDLE: begin
                    txd_o <= 1'b1;
                    if (tx_load) begin
                        tx_sh_ff  <= tx_word;
                        tx_smp_ff <= 4'h0;
                        tx_ph_ff  <= ASP_PH_START;
                        txd_o     <= 1'b0;
                    end
                end
                ASP_PH_START: begin
                    if (tx_bit_end) begin
                        tx_ph_ff  <= ASP_PH_DATA;
                        tx_bit_ff <= 4'h1;
                        txd_o     <= tx_sh_ff[0];
                        tx_sh_ff  <= {1'b0, tx_sh_ff[8:1]};
                    end
                end
                ASP_PH_DATA: begin
                    if (tx_bit_end) begin
                        if (tx_bit_ff == nbits) begin
                            tx_ph_ff  <= ASP_PH_STOP;
                            tx_bit_ff <= 4'h1;
                            txd_o     <= 1'b1;
                        end else begin
                            tx_bit_ff <= tx_bit_ff + 4'h1;
                            txd_o     <= tx_sh_ff[0];
                            tx_sh_ff  <= {1'b0, tx_sh_ff[8:1]};
                        end
                    end
                end
                ASP_PH_STOP: begin
                    if (tx_bit_end) begin
                        if (ctrl_ff[ASP_CTRL_TWOSTP] && tx_bit_ff == 4'h1) begin
                            tx_bit_ff <= 4'h2;
                        end else begin
                            tx_ph_ff <= ASP_PH_IDLE;
                        end
                    end
                end
                default: tx_ph_ff <= ASP_PH_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Receiver; the pin crosses in through two flip-flops
    logic        rxd_m_ff;
    logic        rxd_s_ff;
    asp_ph_t     rx_ph_ff;
    logic [3:0]  rx_smp_ff;
    logic [3:0]  rx_bit_ff;
    logic [8:0]  rx_sh_ff;
    logic [2:0]  votes_ff;
    logic        noisy_ff;
    logic        vote;
    logic        vote_noisy;
    logic        rx_bit_end;
    logic        rx_done;
    logic        rx_stop_bad;
    logic        rx_par_bad;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxd_m_ff <= 1'b1;
            rxd_s_ff <= 1'b1;
        end else begin
            rxd_m_ff <= rxd_i;
            rxd_s_ff <= rxd_m_ff;
        end
    end

    assign vote        = (votes_ff[0] & votes_ff[1]) | (votes_ff[0] & votes_ff[2])
                         | (votes_ff[1] & votes_ff[2]);
    assign vote_noisy  = ~(&votes_ff) & (|votes_ff);
    assign rx_bit_end  = tick & (rx_smp_ff == ASP_BIT_END);
    // Stop judged early, at sample 10, so no start edge is missed
    assign rx_done     = tick & (rx_ph_ff == ASP_PH_STOP) & (rx_smp_ff == ASP_SMP_C + 4'h1);
    assign rx_stop_bad = ~vote;
    assign rx_par_bad  = ctrl_ff[ASP_CTRL_PAR_EN] & (ctrl_ff[ASP_CTRL_PAR_OD] ^
                         (ctrl_ff[ASP_CTRL_NINE] ? ^rx_sh_ff : ^rx_sh_ff[8:1]));

    // Receive sequencer, 3-sample vote
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_ph_ff  <= ASP_PH_IDLE;
            rx_smp_ff <= 4'h0;
            rx_bit_ff <= 4'h0;
            rx_sh_ff  <= 9'h000;
            votes_ff  <= 3'h7;
            noisy_ff  <= 1'b0;
        end else if (tick) begin
            rx_smp_ff <= rx_smp_ff + 4'h1;
            if (rx_smp_ff >= ASP_SMP_A && rx_smp_ff <= ASP_SMP_C) begin
                votes_ff <= {votes_ff[1:0], rxd_s_ff};
            end
            case (rx_ph_ff)
                ASP_PH_IDLE: begin
                    if (!rxd_s_ff && ctrl_ff[ASP_CTRL_RX_EN]) begin
                        rx_ph_ff  <= ASP_PH_START;
                        rx_smp_ff <= 4'h1;
                        noisy_ff  <= 1'b0;
                    end
                end
                ASP_PH_START: begin
                    if (rx_bit_end) begin
                        // A start that votes high was a glitch
                        rx_ph_ff  <= vote ? ASP_PH_IDLE : ASP_PH_DATA;
                        rx_bit_ff <= 4'h1;
                        noisy_ff  <= vote_noisy;
                    end
                end
                ASP_PH_DATA: begin
                    if (rx_bit_end) begin
                        rx_sh_ff  <= {vote, rx_sh_ff[8:1]};
                        noisy_ff  <= noisy_ff | vote_noisy;
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                        if (rx_bit_ff == nbits) begin
                            rx_ph_ff <= ASP_PH_STOP;
                        end
                    end
                end
                ASP_PH_STOP: begin
                    if (rx_done) begin
                        rx_ph_ff <= ASP_PH_IDLE;
                    end
                end
                default: rx_ph_ff <= ASP_PH_IDLE;
            endcase
        end
    end

    // Receive buffer; a full buffer keeps its character
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_buf_ff   <= ASP_DATA_RST;
            rx_ninth_ff <= 1'b0;
        end else if (rx_done && !flags_ff[ASP_EV_RX_FULL]) begin
            rx_buf_ff   <= ctrl_ff[ASP_CTRL_NINE] ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
            rx_ninth_ff <= ctrl_ff[ASP_CTRL_NINE] & rx_sh_ff[8];
        end
    end

    // ==========================================================
    // Flags: status read arms, data access clears.
    // Set wins over clear.
    logic [ASP_EV_W-1:0] flag_set;
    logic [ASP_EV_W-1:0] flag_clr;
    logic                rx_ok;

    assign rx_ok = rx_done & ~flags_ff[ASP_EV_RX_FULL];

    always_comb begin
        flag_set                 = '0;
        flag_set[ASP_EV_RX_FULL] = rx_ok;
        flag_set[ASP_EV_OVERRUN] = rx_done & flags_ff[ASP_EV_RX_FULL];
        flag_set[ASP_EV_NOISE]   = rx_ok & (noisy_ff | vote_noisy);
        flag_set[ASP_EV_FRAMING] = rx_ok & rx_stop_bad;
        flag_set[ASP_EV_PARITY]  = rx_ok & rx_par_bad;
        flag_set[ASP_EV_TX_EMPT] = tx_load;
        flag_set[ASP_EV_TX_DONE] = tx_bit_end & (tx_ph_ff == ASP_PH_STOP) & flags_ff[ASP_EV_TX_EMPT];
        flag_clr = '0;
        if (data_rd) begin
            flag_clr[ASP_EV_OVERRUN:ASP_EV_PARITY] = armed_ff[ASP_EV_OVERRUN:ASP_EV_PARITY];
            flag_clr[ASP_EV_RX_FULL]               = armed_ff[ASP_EV_RX_FULL];
        end
        if (data_wr) begin
            flag_clr[ASP_EV_TX_EMPT] = armed_ff[ASP_EV_TX_EMPT];
            flag_clr[ASP_EV_TX_DONE] = armed_ff[ASP_EV_TX_EMPT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_ff <= ASP_EV_RST;
        end else begin
            flags_ff <= (flags_ff & ~flag_clr) | flag_set;
        end
    end

    // Flags seen by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_ff <= '0;
        end else if (stat_rd) begin
            armed_ff <= flags_ff;
        end else begin
            armed_ff <= armed_ff & ~flag_clr;
        end
    end

    // ==========================================================
    // Sticky copy refreshed while a flag stays high,
    // so a W1C only works once the flag is gone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sticky_ff <= '0;
        end else if (wr_go && idx == ASP_IDX_IRQ_ST) begin
            sticky_ff <= (sticky_ff & ~wb_dat_i[ASP_EV_W-1:0]) | flags_ff;
        end else begin
            sticky_ff <= sticky_ff | flags_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(sticky_ff & err_en_ff);
        end
    end

endmodule : asp_serial_port

// ==== asp_serial_port_checker.sv ====
// Port-level checker for the serial data port.
`timescale 1ns/1ns
module asp_serial_port_checker (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [asp_pkg::ASP_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    input  wire logic [31:0]                   wb_dat_o,
    input  wire logic                          wb_ack_o,
    input  wire logic                          txd_o,
    input  wire logic                          irq_o
);
    import asp_pkg::*;

    // ==========================================================
    // Shadow of the interrupt mask
    logic [ASP_EV_W-1:0] en_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_ff <= ASP_EN_RST;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                     && wb_adr_i[4:2] == ASP_IDX_ERR_EN) begin
            en_ff <= wb_dat_i[ASP_EV_W-1:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ==========================================================
    // Bus handshake steps
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_bus_answer: assert property (s_req |=> s_ans)
        else $error("bad ack timing");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[4:2] == 3'h6 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_reset_idle: assert property ($fell(rst_i) |-> txd_o && !wb_ack_o && !irq_o)
        else $error("not idle after reset");
    // Bits hold for at least nine clocks
    a_low_bit_hold: assert property ($fell(txd_o) |=> $stable(txd_o)[*8])
        else $error("low bit too short");
    a_high_bit_hold: assert property ($rose(txd_o) |=> $stable(txd_o)[*8])
        else $error("high bit too short");
    a_irq_needs_en: assert property (irq_o |-> $past(en_ff) != '0)
        else $error("irq while masked");
    // Request drops only after a write
    a_irq_falls_write: assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i, 2))
        else $error("irq fell without write");
endmodule : asp_serial_port_checker

// ==== asp_remote.sv ====
// Remote asynchronous serial device model.
`timescale 1ns/1ns
module asp_remote #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    logic [7:0] rx_byte = 8'h00;
    logic       rx_stop = 1'b0;
    int         rx_cnt  = 0;

    // Idle high, no shared clock
    initial rxd_o = 1'b1;

    // One frame; glitch upsets one vote of bit 0
    task automatic send(input logic [7:0] b, input logic bad_stop, input logic glitch);
        logic [9:0] fr;
        fr = {~bad_stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            for (int c = 0; c < BIT_CLKS; c++) begin
                @(posedge clk_i);
                rxd_o <= fr[i] ^ (glitch && i == 1 && (c == 9 || c == 10));
            end
        end
        @(posedge clk_i);
        rxd_o <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_i);
    endtask : send

    // Mid-bit sampling, LSB first
    initial begin
        forever begin
            @(negedge txd_i);
            repeat (BIT_CLKS / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CLKS) @(posedge clk_i);
                rx_byte[i] = txd_i;
            end
            repeat (BIT_CLKS) @(posedge clk_i);
            rx_stop = txd_i;
            rx_cnt++;
        end
    end
endmodule : asp_remote

// ==== tb_asp_serial_port.sv ====
// Self-checking bench for the serial data port.
`timescale 1ns/1ns
module tb_asp_serial_port;
    import asp_pkg::*;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [4:0]  wb_adr_i = 5'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        rxd_i;
    logic        txd_o;
    logic        irq_o;
    int          err_count = 0;
    int          n_tests   = 0;
    int          cyc_cnt   = 0;

    always #4 clk_i = ~clk_i;

    asp_serial_port u_asp_serial_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rxd_i(rxd_i), .txd_o(txd_o), .irq_o(irq_o));
    asp_remote u_asp_remote (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

    // ==========================================================
    // Reporting and checks
    task automatic test_done();
        $display("Tests %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("Error at %0t: got %h, exp %h", $time, got, exp);
            err_count++;
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            $display("Error at %0t: got %b, exp %b", $time, got, exp);
            err_count++;
        end
    endtask : chk_bit

    // Hang guard
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 60000) begin
            err_count++;
            test_done();
        end
    end

    // ==========================================================
    // Wishbone classic cycle
    task automatic wb_xfer(input logic we, input logic [2:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= wd;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_xfer
    task automatic wr(input logic [2:0] idx, input logic [31:0] d);
        logic [31:0] x;
        wb_xfer(1'b1, idx, d, x);
    endtask : wr
    task automatic rd(input logic [2:0] idx, output logic [31:0] d);
        wb_xfer(1'b0, idx, 32'h0, d);
    endtask : rd
    // Poll status; each read arms clearing
    task automatic wait_stat(input int b, output logic [31:0] s);
        for (int i = 0; i < 400; i++) begin
            rd(ASP_IDX_STAT, s);
            if (s[b] === 1'b1) break;
        end
    endtask : wait_stat
    task automatic wait_rx(input int n);
        for (int i = 0; i < 3000 && u_asp_remote.rx_cnt < n; i++) @(posedge clk_i);
    endtask : wait_rx

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] d;
        rd(ASP_IDX_DATA, d);
        chk_val(d, {24'h0, ASP_DATA_RST});
        rd(ASP_IDX_STAT, d);
        chk_val(d, {25'h0, ASP_EV_RST});
        rd(ASP_IDX_ERR_EN, d);
        chk_val(d, {25'h0, ASP_EN_RST});
        wr(3'h6, 32'hFF);
        rd(3'h6, d);
        chk_val(d, 32'h0);
        chk_bit(irq_o, 1'b0);
        $display("t_reset done");
    endtask : t_reset
    // Second char queued while first shifts
    task automatic t_tx();
        logic [31:0] d;
        int c;
        c = u_asp_remote.rx_cnt;
        rd(ASP_IDX_STAT, d);
        wr(ASP_IDX_DATA, 32'hA5);
        wait_stat(ASP_EV_TX_EMPT, d);
        wr(ASP_IDX_DATA, 32'h3C);
        wait_rx(c + 1);
        chk_val({24'h0, u_asp_remote.rx_byte}, 32'hA5);
        chk_bit(u_asp_remote.rx_stop, 1'b1);
        wait_rx(c + 2);
        chk_val({24'h0, u_asp_remote.rx_byte}, 32'h3C);
        rd(ASP_IDX_DATA, d);
        chk_val(d, 32'h0);
        $display("t_tx done");
    endtask : t_tx
    task automatic t_rx();
        logic [31:0] d;
        u_asp_remote.send(8'h5A, 1'b0, 1'b0);
        wait_stat(ASP_EV_RX_FULL, d);
        rd(ASP_IDX_NINTH, d);
        chk_val(d, 32'h0);
        rd(ASP_IDX_DATA, d);
        chk_val(d, 32'h5A);
        rd(ASP_IDX_STAT, d);
        chk_bit(d[ASP_EV_RX_FULL], 1'b0);
        $display("t_rx done");
    endtask : t_rx
    // One error event, masked or enabled
    task automatic t_event(input int e, input logic m);
        logic [31:0] s;
        logic [7:0] b;
        b = (e == ASP_EV_PARITY) ? 8'h01 : ((e == ASP_EV_NOISE) ? 8'h00 : 8'h55);
        wr(ASP_IDX_CTRL, {26'h0, ASP_CTRL_RST} | ((e == ASP_EV_PARITY) ? 32'h4 : 32'h0));
        wr(ASP_IDX_ERR_EN, m ? (32'h1 << e) : 32'h0);
        u_asp_remote.send(b, e == ASP_EV_FRAMING, e == ASP_EV_NOISE);
        if (e == ASP_EV_OVERRUN) u_asp_remote.send(~b, 1'b0, 1'b0);
        wait_stat(e, s);
        chk_bit(s[e], 1'b1);
        repeat (3) @(posedge clk_i);
        chk_bit(irq_o, m);
        rd(ASP_IDX_DATA, s);
        if (e == ASP_EV_OVERRUN) chk_val(s, {24'h0, b});
        wr(ASP_IDX_IRQ_ST, 32'h7F);
        repeat (3) @(posedge clk_i);
        chk_bit(irq_o, 1'b0);
        rd(ASP_IDX_STAT, s);
        chk_val(s & 32'h1F, 32'h0);
        $display("t_event %0d mask %0d done", e, m);
    endtask : t_event

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        wr(ASP_IDX_BAUD, 32'h1);
        t_tx();
        t_rx();
        for (int e = 0; e < 4; e++) begin
            t_event(e, 1'b0);
            t_event(e, 1'b1);
        end
        test_done();
    end
endmodule : tb_asp_serial_port

bind asp_serial_port asp_serial_port_checker u_asp_serial_port_checker (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_o(txd_o), .irq_o(irq_o));
